// ### bench/ssm_monitor_tb.sv
// self-checking bench of the speed monitor control
// assumes shortened counts: ack 20..100, self-test 8 cycles
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_monitor_tb;
    logic              core_clk;
    logic              nrst;
    logic              self_test_fail;
    logic              mode_input_a;
    logic              mode_input_b;
    logic              ext_error;
    ssm_pkg::ssm_cfg_t cfg;
    logic [15:0]       freq_a;
    logic [15:0]       freq_b;
    logic              ack_in;
    logic              relay_a;
    logic              relay_b;
    logic              enable_state_output;
    logic              readiness_output;
    logic              led_ok_green;
    logic              led_ok_red;
    logic [5:0]        obs;
    int                errors          = 0;
    int                samples_checked = 0;

    // =================================================================
    // clock, design and far side
    always #12.5 core_clk = ~core_clk;
    assign obs = {relay_a, relay_b, enable_state_output,
                  readiness_output, led_ok_green, led_ok_red};

    ssm_monitor #(
        .ACK_MIN_CYC  (20),
        .ACK_MAX_CYC  (100),
        .SELFTEST_CYC (8),
        .SEC_CYC      (10)
    ) u_dut (
        .core_clk            (core_clk),
        .nrst                (nrst),
        .cfg                 (cfg),
        .freq_a              (freq_a),
        .freq_b              (freq_b),
        .self_test_fail      (self_test_fail),
        .ack_in              (ack_in),
        .mode_input_a        (mode_input_a),
        .mode_input_b        (mode_input_b),
        .ext_error           (ext_error),
        .relay_a             (relay_a),
        .relay_b             (relay_b),
        .enable_state_output (enable_state_output),
        .readiness_output    (readiness_output),
        .led_ok_green        (led_ok_green),
        .led_ok_red          (led_ok_red)
    );

    ssm_partner u_part (
        .core_clk (core_clk),
        .freq_a   (freq_a),
        .freq_b   (freq_b),
        .ack_in   (ack_in)
    );

    // =================================================================
    // compare, model and closing
    task automatic chk(logic [5:0] seen, logic [5:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // model: path state and readiness give all six outputs
    task automatic look(int on, int rdy);
        logic [5:0] e;
        e = {on[0], on[0], on[0], rdy[0], rdy[0], ~rdy[0]};
        repeat (10) @(negedge core_clk);
        chk(obs, e);
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // reset with a new mode, then self-test and readiness
    task automatic boot(ssm_pkg::ssm_mode_t md, logic man, int lo);
        @(negedge core_clk);
        nrst = 1'b0;
        cfg.mode = md;
        cfg.ack_manual = man;
        cfg.low_freq_limit = 16'(lo);
        repeat (4) @(negedge core_clk);
        chk(obs, 6'h01);
        nrst = 1'b1;
        repeat (2) @(negedge core_clk);
        chk(obs, 6'h01);
        repeat (10) @(negedge core_clk);
        look(0, int'(!self_test_fail));
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end

    // =================================================================
    // scenarios
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        self_test_fail = 1'b0;
        mode_input_a = 1'b0;
        mode_input_b = 1'b0;
        ext_error = 1'b0;
        cfg = '{mode: ssm_pkg::SSM_MODE_RANGE_NOSUP, ack_manual: 1'b1,
                low_freq_limit: 16'h0064, high_freq_limit_first: 16'h01F4,
                high_freq_limit_second: 16'h0320, hysteresis: 16'h0014,
                startup_supervision_time: 6'h00};
        void'($urandom(32'h69f2));
        // acknowledge window and speed limits, manual range mode
        boot(ssm_pkg::SSM_MODE_RANGE_NOSUP, 1'b1, 100);
        u_part.f = 150 + int'($urandom % 300);
        u_part.pulse(10); look(0, 1);
        u_part.pulse(150); look(0, 1);
        u_part.pulse(50); look(1, 1);
        u_part.f = 600; look(0, 1);
        u_part.pulse(50); look(0, 1);
        u_part.f = 490; u_part.pulse(50); look(0, 1);
        u_part.f = 400; u_part.pulse(50); look(1, 1);
        u_part.f = 50; look(0, 1);
        u_part.pulse(50); look(0, 1);
        u_part.f = 300; u_part.pulse(50); look(1, 1);
        u_part.skew = 300; look(0, 0);
        u_part.skew = 0; look(0, 0);
        u_part.pulse(50); look(0, 1);
        u_part.pulse(50); look(1, 1);
        ext_error = 1'b1; look(0, 0);
        ext_error = 1'b0; u_part.pulse(50); look(0, 1);
        // failed self-test, then start-up window of one second
        self_test_fail = 1'b1; cfg.startup_supervision_time = 6'h01;
        boot(ssm_pkg::SSM_MODE_RANGE_SUP, 1'b1, 100);
        self_test_fail = 1'b0; u_part.f = 50;
        u_part.pulse(50); look(0, 1);
        u_part.pulse(50); look(1, 1);
        look(0, 1);
        u_part.pulse(50); u_part.f = 300; look(1, 1);
        look(1, 1);
        boot(ssm_pkg::SSM_MODE_RANGE_SUP, 1'b1, 0);
        u_part.f = 0; u_part.pulse(50); look(1, 1);
        look(1, 1);
        // second limit or muting while both inputs high, then automatic acknowledge
        boot(ssm_pkg::SSM_MODE_DUAL_MAX, 1'b1, 100);
        u_part.f = 150 + int'($urandom % 300);
        u_part.pulse(50); look(1, 1);
        mode_input_a = 1'b1; mode_input_b = 1'b1; look(1, 1);
        u_part.f = 700; look(1, 1);
        mode_input_a = 1'b0; mode_input_b = 1'b0; look(0, 1);
        boot(ssm_pkg::SSM_MODE_MUTING, 1'b1, 100);
        u_part.f = 150 + int'($urandom % 300);
        u_part.pulse(50); look(1, 1);
        mode_input_a = 1'b1; mode_input_b = 1'b1; look(1, 1);
        u_part.f = 900; look(1, 1);
        mode_input_a = 1'b0; mode_input_b = 1'b0; look(0, 1);
        u_part.f = 600; u_part.hold(1'b1);
        boot(ssm_pkg::SSM_MODE_MAX_ONLY, 1'b0, 100);
        u_part.f = 300; look(1, 1);
        u_part.f = 600; look(0, 1);
        u_part.f = 300; look(1, 1);
        test_done();
    end
endmodule // ssm_monitor_tb

// ### bench/ssm_partner.sv
// far side of the monitor: motor terminals and acknowledge switch
// assumes the bench sets f, skew and ack level between falling edges
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_partner (
    input  wire logic               core_clk,
    output logic [`SSM_FW-1:0]      freq_a,
    output logic [`SSM_FW-1:0]      freq_b,
    output logic                    ack_in
);
    int f    = 0; // rotating field, 0.1 Hz steps
    int skew = 0; // extra offset seen by channel b only

    // =================================================================
    // measuring terminals
    // limits and frequency in 0.1 Hz steps
    assign freq_a = 16'(f);
    assign freq_b = 16'(f + skew);

    // =================================================================
    // acknowledge switch, open (low) when idle
    initial ack_in = 1'b0;

    // auto mode holds the level high
    task automatic hold(logic lvl);
        @(negedge core_clk);
        ack_in = lvl;
    endtask

    // manual pulse of n cycles, then a falling edge
    task automatic pulse(int n);
        @(negedge core_clk);
        ack_in = 1'b1;
        repeat (n) @(negedge core_clk);
        ack_in = 1'b0;
    endtask
endmodule // ssm_partner

// ### rtl/ssm_chan.sv
// one evaluation channel: limit comparison on a measured frequency
// assumes freq is a same-clock word from the measuring front end
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_chan #(
    parameter int FW = `SSM_FW
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [FW-1:0]    freq,
    input  wire ssm_pkg::ssm_cfg_t cfg,
    input  wire logic             sel_second,
    output ssm_pkg::ssm_cmp_t     cmp
);

    ssm_pkg::ssm_cmp_t next_cmp;
    logic [FW-1:0]     hi_lim;

    if (FW != `SSM_FW) begin : g_bad_width
        $error("ssm_chan: FW must match the configuration word");
    end

    // saturating subtract and add of limit words
    function automatic logic [FW-1:0] lim_sub(input logic [FW-1:0] a,
                                              input logic [FW-1:0] b);
        lim_sub = (a > b) ? a - b : '0;
    endfunction

    function automatic logic [FW-1:0] lim_add(input logic [FW-1:0] a,
                                              input logic [FW-1:0] b);
        logic [FW:0] s;
        s = {1'b0, a} + {1'b0, b};
        lim_add = s[FW] ? '1 : s[FW-1:0];
    endfunction

    // =================================================================
    // comparisons; release always against first limit less hysteresis
    always_comb begin
        hi_lim = sel_second ? cfg.high_freq_limit_second
                            : cfg.high_freq_limit_first;
        next_cmp.over        = freq > hi_lim;
        next_cmp.over_clear  = freq < lim_sub(cfg.high_freq_limit_first,
                                              cfg.hysteresis);
        next_cmp.under       = (cfg.low_freq_limit != `SSM_FREQ_ZERO) &&
                               (freq < cfg.low_freq_limit);
        next_cmp.min_reached = freq >= lim_add(cfg.low_freq_limit,
                                               cfg.hysteresis);
        next_cmp.moving      = freq > `SSM_MOVING_FREQ;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmp <= '0;
        end else begin
            cmp <= next_cmp;
        end
    end

endmodule // ssm_chan

// ### rtl/ssm_consts.svh
// constants of the speed monitor: times, widths, frequency steps
// assumes frequencies are unsigned words in 0.1 Hz steps
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// =====================================================================
// clock and time
`define SSM_CLK_HZ       32'h0262_5A00 // 40 MHz core clock
`define SSM_MS_PER_S     32'h0000_03E8 // 1000 ms in one second
`define SSM_ACK_MIN_MS   32'h0000_00C8 // 200 ms shortest acknowledge
`define SSM_ACK_MAX_MS   32'h0000_1388 // 5000 ms longest acknowledge
`define SSM_SELFTEST_MS  32'h0000_0064 // 100 ms self-test duration
`define SSM_TSUP_MAX_S   6'h3C         // 60 s longest start-up time

// =====================================================================
// frequency words
`define SSM_FW           16            // width of a frequency word
`define SSM_MOVING_FREQ  16'h000A      // 1 Hz: motor counts as moving
`define SSM_FREQ_ZERO    16'h0000      // zero limit disables a check

`endif

// ### rtl/ssm_monitor.sv
// speed monitor control: two-channel limit check, relay pair, ack
// assumes frequency words come from two same-clock measuring channels
// and that pins (ack, mode inputs, external error) are asynchronous
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_monitor #(
    parameter int FW           = `SSM_FW,
    parameter int ACK_MIN_CYC  = `SSM_CLK_HZ / `SSM_MS_PER_S
                                 * `SSM_ACK_MIN_MS,
    parameter int ACK_MAX_CYC  = `SSM_CLK_HZ / `SSM_MS_PER_S
                                 * `SSM_ACK_MAX_MS,
    parameter int SELFTEST_CYC = `SSM_CLK_HZ / `SSM_MS_PER_S
                                 * `SSM_SELFTEST_MS,
    parameter int SEC_CYC      = `SSM_CLK_HZ
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire ssm_pkg::ssm_cfg_t cfg,
    input  wire logic [FW-1:0]     freq_a,
    input  wire logic [FW-1:0]     freq_b,
    input  wire logic              self_test_fail,
    input  wire logic              ack_in,
    input  wire logic              mode_input_a,
    input  wire logic              mode_input_b,
    input  wire logic              ext_error,
    output logic                   relay_a,
    output logic                   relay_b,
    output logic                   enable_state_output,
    output logic                   readiness_output,
    output logic                   led_ok_green,
    output logic                   led_ok_red
);

    localparam int ACW = $clog2(ACK_MAX_CYC + 2);
    localparam int TCW = $clog2(SELFTEST_CYC + 1);
    localparam int SCW = $clog2(SEC_CYC + 1);
    localparam logic [ACW-1:0] ACK_MIN = ACW'(ACK_MIN_CYC);
    localparam logic [ACW-1:0] ACK_MAX = ACW'(ACK_MAX_CYC);
    localparam logic [TCW-1:0] TEST_END = TCW'(SELFTEST_CYC - 1);
    localparam logic [SCW-1:0] SEC_END = SCW'(SEC_CYC - 1);

    if (FW != `SSM_FW || ACK_MIN_CYC < 1 || ACK_MAX_CYC <= ACK_MIN_CYC ||
        SELFTEST_CYC < 1 || SEC_CYC < 1) begin : g_bad_param
        $error("ssm_monitor: unusable parameter values");
    end

    typedef enum logic [1:0] {ST_TEST, ST_OFF, ST_ON, ST_ERR} ssm_state_t;

    // =================================================================
    // pin synchronisers and channel comparators
    logic [3:0]        pin_s;
    logic              ack_lvl;
    logic              in_a;
    logic              in_b;
    logic              ext_s;
    ssm_pkg::ssm_cmp_t cmp_a;
    ssm_pkg::ssm_cmp_t cmp_b;
    logic              sel_second;
    logic              muted;

    ssm_sync #(.W(4)) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      ({ack_in, mode_input_a, mode_input_b, ext_error}),
        .dout     (pin_s)
    );

    assign {ack_lvl, in_a, in_b, ext_s} = pin_s;

    assign sel_second = (cfg.mode == ssm_pkg::SSM_MODE_DUAL_MAX) &&
                        in_a && in_b;
    assign muted = (cfg.mode == ssm_pkg::SSM_MODE_MUTING) && in_a && in_b;

    ssm_chan #(.FW(FW)) u_ch_a (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .freq       (freq_a),
        .cfg        (cfg),
        .sel_second (sel_second),
        .cmp        (cmp_a)
    );

    ssm_chan #(.FW(FW)) u_ch_b (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .freq       (freq_b),
        .cfg        (cfg),
        .sel_second (sel_second),
        .cmp        (cmp_b)
    );

    // =================================================================
    // fault decode
    logic mismatch;
    logic err_now;
    logic min_on;
    logic sup_on;

    assign mismatch = cmp_a != cmp_b;
    assign err_now  = mismatch || ext_s;
    // minimum checked only in range modes with nonzero limit
    assign min_on = (cfg.low_freq_limit != `SSM_FREQ_ZERO) &&
                    (cfg.mode == ssm_pkg::SSM_MODE_RANGE_SUP ||
                     cfg.mode == ssm_pkg::SSM_MODE_RANGE_NOSUP);
    assign sup_on = min_on && (cfg.mode == ssm_pkg::SSM_MODE_RANGE_SUP) &&
                    (cfg.startup_supervision_time != 6'h00);

    // =================================================================
    // manual acknowledge pulse-width check
    logic           ack_prev;
    logic           next_ack_prev;
    logic [ACW-1:0] ack_cnt;
    logic [ACW-1:0] next_ack_cnt;
    logic           ack_ok;
    logic           next_ack_ok;
    logic           ack_evt;

    // count high time, judge it at falling edge
    always_comb begin
        next_ack_prev = ack_lvl;
        next_ack_cnt  = ack_cnt;
        next_ack_ok   = 1'b0;
        if (ack_lvl) begin
            if (ack_cnt <= ACK_MAX) begin
                next_ack_cnt = ack_cnt + 1'b1;
            end
        end else begin
            next_ack_cnt = '0;
            if (ack_prev) begin
                next_ack_ok = (ack_cnt >= ACK_MIN) && (ack_cnt <= ACK_MAX);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_prev <= 1'b0;
            ack_cnt  <= '0;
            ack_ok   <= 1'b0;
        end else begin
            ack_prev <= next_ack_prev;
            ack_cnt  <= next_ack_cnt;
            ack_ok   <= next_ack_ok;
        end
    end

    // automatic mode takes the steady level as acknowledge
    assign ack_evt = cfg.ack_manual ? ack_ok : ack_lvl;

    // =================================================================
    // start-up supervision timer
    ssm_state_t     state;
    ssm_state_t     next_state;
    logic           start_sup;
    logic           sup_run;
    logic           next_sup_run;
    logic [SCW-1:0] sec_cnt;
    logic [SCW-1:0] next_sec_cnt;
    logic [5:0]     sup_left;
    logic [5:0]     next_sup_left;
    logic           sup_exp;
    logic           next_sup_exp;

    // loads only when idle, so no retrigger while running
    always_comb begin
        next_sup_run  = sup_run;
        next_sec_cnt  = sec_cnt;
        next_sup_left = sup_left;
        next_sup_exp  = 1'b0;
        if (!sup_run) begin
            if (start_sup) begin
                next_sup_run  = 1'b1;
                next_sec_cnt  = '0;
                next_sup_left = (cfg.startup_supervision_time >
                                 `SSM_TSUP_MAX_S) ? `SSM_TSUP_MAX_S
                                : cfg.startup_supervision_time;
            end
        end else if (state != ST_ON || cmp_a.min_reached) begin
            next_sup_run = 1'b0;
        end else if (sec_cnt == SEC_END) begin
            next_sec_cnt = '0;
            if (sup_left <= 6'h01) begin
                next_sup_run = 1'b0;
                next_sup_exp = 1'b1;
            end else begin
                next_sup_left = sup_left - 1'b1;
            end
        end else begin
            next_sec_cnt = sec_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sup_run  <= 1'b0;
            sec_cnt  <= '0;
            sup_left <= 6'h00;
            sup_exp  <= 1'b0;
        end else begin
            sup_run  <= next_sup_run;
            sec_cnt  <= next_sec_cnt;
            sup_left <= next_sup_left;
            sup_exp  <= next_sup_exp;
        end
    end

    // =================================================================
    // main state machine and registered outputs
    logic           trip_over;
    logic           trip_under;
    logic           ok_close;
    logic [TCW-1:0] test_cnt;
    logic [TCW-1:0] next_test_cnt;
    logic           next_relay;
    logic           next_ready;
    logic           next_red;

    assign trip_over  = cmp_a.over && !muted;
    assign trip_under = min_on && cmp_a.under && !sup_run && !muted;
    // reclose only with every speed fault gone (minimum waived under start-up supervision), or while muted
    assign ok_close = muted ||
        (cmp_a.over_clear && (!min_on || sup_on || cmp_a.min_reached) &&
         (!(sup_on && !cfg.ack_manual) || cmp_a.moving));

    always_comb begin
        next_state    = state;
        next_test_cnt = test_cnt;
        start_sup     = 1'b0;
        unique case (state)
            ST_TEST: begin
                next_test_cnt = test_cnt + 1'b1;
                if (test_cnt == TEST_END) begin
                    next_state = self_test_fail ? ST_ERR : ST_OFF;
                end
            end
            ST_OFF: begin
                if (err_now) begin
                    next_state = ST_ERR;
                end else if (ack_evt && ok_close) begin
                    next_state = ST_ON;
                    start_sup  = sup_on && !muted;
                end
            end
            // open on unmuted overspeed, on underspeed while start-up timer idle, on its expiry or on error
            ST_ON: begin
                if (err_now) begin
                    next_state = ST_ERR;
                end else if (trip_over || trip_under || sup_exp) begin
                    next_state = ST_OFF;
                end
            end
            ST_ERR: begin
                if (cfg.ack_manual && ack_ok && !err_now) begin
                    next_state = ST_OFF;
                end
            end
        endcase
        next_relay = next_state == ST_ON;
        // ready only outside test and error
        next_ready = next_state == ST_OFF || next_state == ST_ON;
        next_red   = !next_ready;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state               <= ST_TEST;
            test_cnt            <= '0;
            relay_a             <= 1'b0;
            relay_b             <= 1'b0;
            enable_state_output <= 1'b0;
            readiness_output    <= 1'b0;
            led_ok_green        <= 1'b0;
            led_ok_red          <= 1'b1;
        end else begin
            state               <= next_state;
            test_cnt            <= next_test_cnt;
            relay_a             <= next_relay;
            relay_b             <= next_relay;
            enable_state_output <= next_relay;
            readiness_output    <= next_ready;
            led_ok_green        <= next_ready;
            led_ok_red          <= next_red;
        end
    end

    // =================================================================
    // checks
    a_relays_together: assert property (@(posedge core_clk)
        disable iff (!nrst) relay_a == relay_b)
        else $error("relay channels differ");
    a_status_follows: assert property (@(posedge core_clk)
        disable iff (!nrst) enable_state_output == relay_a)
        else $error("first status output does not follow path");
    a_test_open_red: assert property (@(posedge core_clk)
        disable iff (!nrst) state == ST_TEST |-> !relay_a && led_ok_red)
        else $error("path closed or not red during self-test");
    a_test_pass_green: assert property (@(posedge core_clk)
        disable iff (!nrst) state == ST_TEST && test_cnt == TEST_END &&
        !self_test_fail |=> led_ok_green && !led_ok_red)
        else $error("no green after passed self-test");
    a_over_opens: assert property (@(posedge core_clk)
        disable iff (!nrst) state == ST_ON && trip_over |=> !relay_a)
        else $error("overspeed did not open path");
    a_under_opens: assert property (@(posedge core_clk)
        disable iff (!nrst) state == ST_ON && trip_under |=> !relay_b)
        else $error("underspeed did not open path");
    a_error_drops_ready: assert property (@(posedge core_clk)
        disable iff (!nrst) err_now && state != ST_TEST
        |=> !readiness_output && !relay_a)
        else $error("error left readiness or path on");
    a_mismatch_error: assert property (@(posedge core_clk)
        disable iff (!nrst) $rose(mismatch) && state != ST_TEST
        |=> state == ST_ERR)
        else $error("channel disagreement not treated as error");
    a_short_ack_ignored: assert property (@(posedge core_clk)
        disable iff (!nrst) $fell(ack_lvl) && ack_cnt < ACK_MIN
        |=> !ack_ok)
        else $error("short acknowledge pulse accepted");
    a_ack_window: assert property (@(posedge core_clk)
        disable iff (!nrst) ack_ok |-> $past(ack_cnt) >= ACK_MIN &&
        $past(ack_cnt) <= ACK_MAX && !ack_lvl)
        else $error("acknowledge outside pulse window");
    a_sup_no_retrig: assert property (@(posedge core_clk)
        disable iff (!nrst) sup_run && $past(sup_run)
        |-> sup_left <= $past(sup_left))
        else $error("start-up timer restarted while running");

endmodule // ssm_monitor

// ### rtl/ssm_pkg.sv
// types shared by the speed monitor modules
// assumes ssm_consts.svh is on the include path
`include "ssm_consts.svh"

package ssm_pkg;

    // =================================================================
    // monitoring modes selected at configuration
    typedef enum logic [2:0] {
        SSM_MODE_MAX_ONLY,
        SSM_MODE_RANGE_SUP,
        SSM_MODE_RANGE_NOSUP,
        SSM_MODE_DUAL_MAX,
        SSM_MODE_MUTING
    } ssm_mode_t;

    // =================================================================
    // static configuration word
    typedef struct packed {
        ssm_mode_t              mode;
        logic                   ack_manual;
        logic [`SSM_FW-1:0]     low_freq_limit;
        logic [`SSM_FW-1:0]     high_freq_limit_first;
        logic [`SSM_FW-1:0]     high_freq_limit_second;
        logic [`SSM_FW-1:0]     hysteresis;
        logic [5:0]             startup_supervision_time;
    } ssm_cfg_t;

    // comparison flags of one evaluation channel
    typedef struct packed {
        logic under;
        logic over;
        logic over_clear;
        logic min_reached;
        logic moving;
    } ssm_cmp_t;

endpackage

// ### rtl/ssm_sync.sv
// two-stage synchroniser for asynchronous pin levels
// assumes inputs are quasi-static levels from terminals
`timescale 1ns/10ps

module ssm_sync #(
    parameter int W = 4
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1;

    // =================================================================
    // first stage feeds only the second
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule // ssm_sync
